// *** rtl/irq_prio_select.sv ***
// Purpose: Picks the highest-priority active source, lowest number on ties
// Assumes: active already includes enable; source 0 excluded by caller
// Notes:   Scan runs downward so lower numbers overwrite on equal priority
`timescale 1ns/1ps
`default_nettype none
module irq_prio_select #(
    parameter int NUM_SRC = irq_vec_pkg::NUM_SRC
) (
    input  wire logic [NUM_SRC-1:0]                      active,
    input  wire logic [NUM_SRC*irq_vec_pkg::PRIO_W-1:0] prio_flat,
    irq_sel_if.sel                                       sel
);
    localparam int SW = irq_vec_pkg::SRC_W;

    always_comb
    begin
        sel.found     = 1'b0;
        sel.best_src  = irq_vec_pkg::SRC_RESET;
        sel.best_prio = irq_vec_pkg::LEVEL_RESET;
        for (int i = NUM_SRC - 1; i >= 0; i--)
        begin
            if (active[i] && (!sel.found
                || prio_flat[i*irq_vec_pkg::PRIO_W +: irq_vec_pkg::PRIO_W] >= sel.best_prio))
            begin
                sel.found     = 1'b1;
                sel.best_src  = SW'(i);
                sel.best_prio = prio_flat[i*irq_vec_pkg::PRIO_W +: irq_vec_pkg::PRIO_W];
            end
        end
    end
endmodule
`default_nettype wire

// *** rtl/irq_sel_if.sv ***
// Purpose: Carries the arbiter result between selector and controller
// Assumes: Single clock domain, purely combinational result
// Notes:   Found is low when no candidate is active
`timescale 1ns/1ps
`default_nettype none
interface irq_sel_if;
    logic [irq_vec_pkg::SRC_W-1:0]  best_src;
    logic [irq_vec_pkg::PRIO_W-1:0] best_prio;
    logic                           found;
    modport sel (output best_src, output best_prio, output found);
    modport ctl (input best_src, input best_prio, input found);
endinterface
`default_nettype wire

// *** rtl/irq_vec_pkg.sv ***
// Purpose: Shared constants for the vectored priority interrupt path
// Assumes: Eight priority levels, 32 sources, 32-bit handler addresses
// Notes:   Source 0 belongs to the fast path and never wins here
package irq_vec_pkg;
    localparam int          NUM_SRC      = 32;
    localparam int          SRC_W        = 5;
    localparam int          PRIO_W       = 3;
    localparam int          STACK_DEPTH  = 8;
    localparam int          VEC_W        = 32;
    localparam logic [31:0] VEC_RESET    = 32'h0000_0000;
    localparam logic [2:0]  LEVEL_RESET  = 3'h0;
    localparam logic [4:0]  SRC_RESET    = 5'h00;
    localparam logic [3:0]  SP_RESET     = 4'h0;
endpackage

// *** rtl/irq_vectoring_nesting.sv ***
// Purpose: Normal interrupt request path with vectoring and nesting stack
// Assumes: Source inputs are asynchronous; core accesses are single-cycle strobes
// Notes:   Vector data is valid one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Vector read makes best source current
// - Vector read drops the request line
// - Vector read clears edge source pending
// - Vector read pushes level and source
// - Vector read returns stored handler address
// - Higher priority than level re-raises request
// - End-of-service pops, restores previous level
// - After pop, above restored level re-raises
// - Equal priority picks lowest source number
// - Stack holds eight nested entries
module irq_vectoring_nesting #(
    parameter int NUM_SRC     = irq_vec_pkg::NUM_SRC,
    parameter int STACK_DEPTH = irq_vec_pkg::STACK_DEPTH
) (
    input  wire logic                                    clk,
    input  wire logic                                    reset,
    input  wire logic                                    clk_en,
    input  wire logic [NUM_SRC-1:0]                      src_in,
    input  wire logic [NUM_SRC-1:0]                      src_enable,
    input  wire logic [NUM_SRC-1:0]                      src_edge_mode,
    input  wire logic [NUM_SRC*irq_vec_pkg::PRIO_W-1:0] src_prio,
    input  wire logic                                    vec_wr,
    input  wire logic [irq_vec_pkg::SRC_W-1:0]          vec_wr_idx,
    input  wire logic [irq_vec_pkg::VEC_W-1:0]          vec_wr_data,
    input  wire logic                                    vector_read_reg,
    input  wire logic                                    end_of_service_reg,
    output logic                                         core_request_n,
    output logic [irq_vec_pkg::VEC_W-1:0]               vector_data,
    output logic [irq_vec_pkg::PRIO_W-1:0]              current_level,
    output logic [irq_vec_pkg::SRC_W-1:0]               current_source,
    output logic                                         in_service
);
    localparam int PW = irq_vec_pkg::PRIO_W;
    localparam int SW = irq_vec_pkg::SRC_W;

    logic [NUM_SRC-1:0]    sync1_r;
    logic [NUM_SRC-1:0]    sync2_r;
    logic [NUM_SRC-1:0]    prev_r;
    logic [NUM_SRC-1:0]    edge_pend_r;
    logic [NUM_SRC-1:0]    active;
    logic [NUM_SRC-1:0]    above;
    logic [irq_vec_pkg::VEC_W-1:0] vec_mem_r [NUM_SRC];
    logic [PW-1:0]         lvl_stack_r [STACK_DEPTH];
    logic [SW-1:0]         src_stack_r [STACK_DEPTH];
    logic [3:0]            sp_r;
    logic [3:0]            sp_nxt;
    logic [PW-1:0]         level_nxt;
    logic                  ack_block_r;
    logic                  do_push;
    logic                  do_pop;
    logic                  raise;
    logic [NUM_SRC*PW-1:0] prio_flat;

    irq_sel_if sel_all ();
    irq_sel_if sel_hi ();

    // Synchronise asynchronous source pins
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            prev_r  <= '0;
        end
        else if (clk_en)
        begin
            sync1_r <= src_in;
            sync2_r <= sync1_r;
            prev_r  <= sync2_r;
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_SRC; i++)
            active[i] = (i != 0) && src_enable[i] && (src_edge_mode[i] ? edge_pend_r[i] : sync2_r[i]);
    end

    assign prio_flat = src_prio;

    // Sources strictly above the current level; every active source while nothing is in service
    always_comb
    begin
        for (int i = 0; i < NUM_SRC; i++)
            above[i] = active[i] && ((sp_r == '0) || (src_prio[i*PW +: PW] > current_level));
    end

    irq_prio_select #(.NUM_SRC(NUM_SRC)) u_sel_all (
        .active    (active),
        .prio_flat (prio_flat),
        .sel       (sel_all.sel)
    );

    irq_prio_select #(.NUM_SRC(NUM_SRC)) u_sel_hi (
        .active    (above),
        .prio_flat (prio_flat),
        .sel       (sel_hi.sel)
    );

    assign do_push = vector_read_reg && sel_all.found && (sp_r < 4'(STACK_DEPTH));
    assign do_pop  = end_of_service_reg && (sp_r != '0);

    // Edge pending: new edge wins over the acknowledge clear
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            edge_pend_r <= '0;
        else if (clk_en)
        begin
            for (int i = 0; i < NUM_SRC; i++)
            begin
                if (sync2_r[i] && !prev_r[i])
                    edge_pend_r[i] <= 1'b1;
                else if (do_push && sel_all.best_src == SW'(i) && src_edge_mode[i])
                    edge_pend_r[i] <= 1'b0;
            end
        end
    end

    // Handler address store
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NUM_SRC; i++)
                vec_mem_r[i] <= irq_vec_pkg::VEC_RESET;
        end
        else if (clk_en && vec_wr)
            vec_mem_r[vec_wr_idx] <= vec_wr_data;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            vector_data <= irq_vec_pkg::VEC_RESET;
        else if (clk_en && do_push)
            vector_data <= vec_mem_r[sel_all.best_src];
    end

    // Nesting stack
    always_comb
    begin
        sp_nxt    = sp_r;
        level_nxt = current_level;
        if (do_push)
        begin
            sp_nxt    = sp_r + 4'h1;
            level_nxt = sel_all.best_prio;
        end
        else if (do_pop)
        begin
            sp_nxt    = sp_r - 4'h1;
            level_nxt = (sp_r > 4'h1) ? lvl_stack_r[3'(sp_r - 4'h2)] : irq_vec_pkg::LEVEL_RESET;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            sp_r           <= irq_vec_pkg::SP_RESET;
            current_level  <= irq_vec_pkg::LEVEL_RESET;
            current_source <= irq_vec_pkg::SRC_RESET;
            in_service     <= 1'b0;
            for (int i = 0; i < STACK_DEPTH; i++)
            begin
                lvl_stack_r[i] <= irq_vec_pkg::LEVEL_RESET;
                src_stack_r[i] <= irq_vec_pkg::SRC_RESET;
            end
        end
        else if (clk_en)
        begin
            sp_r          <= sp_nxt;
            current_level <= level_nxt;
            in_service    <= (sp_nxt != '0);
            if (do_push)
            begin
                lvl_stack_r[3'(sp_r)] <= sel_all.best_prio;
                src_stack_r[3'(sp_r)] <= sel_all.best_src;
                current_source        <= sel_all.best_src;
            end
            else if (do_pop)
                current_source <= (sp_r > 4'h1) ? src_stack_r[3'(sp_r - 4'h2)] : irq_vec_pkg::SRC_RESET;
        end
    end

    // Acknowledge holds request off for one cycle while state settles
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            ack_block_r <= 1'b0;
        else if (clk_en)
            ack_block_r <= vector_read_reg || end_of_service_reg;
    end

    assign raise = sel_hi.found && !ack_block_r && !vector_read_reg && !end_of_service_reg;

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            core_request_n <= 1'b1;
        else if (clk_en)
        begin
            if (vector_read_reg)
                core_request_n <= 1'b1;
            else
                core_request_n <= !raise;
        end
    end

    a_read_drops_req: assert property (@(posedge clk) disable iff (reset)
        (clk_en && vector_read_reg) |=> core_request_n)
        else $error("request not dropped after vector read");

    a_push_level: assert property (@(posedge clk) disable iff (reset)
        (clk_en && do_push) |=> (current_level == $past(sel_all.best_prio) && sp_r == $past(sp_r) + 4'h1))
        else $error("level not taken on vector read");

    a_vector_value: assert property (@(posedge clk) disable iff (reset)
        (clk_en && do_push) |=> vector_data == vec_mem_r[current_source])
        else $error("wrong handler address returned");

    a_empty_pop: assert property (@(posedge clk) disable iff (reset)
        (clk_en && end_of_service_reg && !vector_read_reg && sp_r == '0) |=> (sp_r == '0 && $stable(current_level)))
        else $error("pop on empty stack changed state");

    a_pop_restore: assert property (@(posedge clk) disable iff (reset)
        (clk_en && do_pop && !do_push && sp_r > 4'h1) |=> (sp_r == $past(sp_r) - 4'h1
        && current_level == lvl_stack_r[3'(sp_r - 4'h1)]))
        else $error("previous level not restored");

    a_stack_bound: assert property (@(posedge clk) disable iff (reset)
        sp_r <= 4'(STACK_DEPTH))
        else $error("stack overflow");

    a_edge_clear: assert property (@(posedge clk) disable iff (reset)
        (clk_en && do_push && src_edge_mode[sel_all.best_src] && !(sync2_r[sel_all.best_src]
        && !prev_r[sel_all.best_src])) |=> !edge_pend_r[current_source])
        else $error("edge source not cleared");

    sequence s_quiet_above;
        clk_en && sel_hi.found && !vector_read_reg && !end_of_service_reg && !ack_block_r;
    endsequence

    a_reraise: assert property (@(posedge clk) disable iff (reset)
        s_quiet_above |=> !core_request_n)
        else $error("request not raised for higher priority");

    a_no_spurious: assert property (@(posedge clk) disable iff (reset)
        (clk_en && !sel_hi.found) |=> core_request_n)
        else $error("request raised without eligible source");
endmodule
`default_nettype wire

// *** sim/core_model.sv ***
// Purpose: Processor core stand-in that takes and acknowledges vectored requests
// Assumes: Acts on the falling edge, one vector read per request
// Notes:   End-of-service strobe comes straight from the bench
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        core_request_n,
    input  wire logic [31:0] vector_data,
    input  wire logic        irq_mask,
    input  wire logic        eos_go,
    output logic             vector_read_reg,
    output logic             end_of_service_reg,
    output logic [31:0]      handler_addr,
    output logic [31:0]      link_addr
);
    logic [31:0] link_r;
    logic [31:0] pc_r;
    logic        adjust_r;

    assign end_of_service_reg = eos_go;
    assign link_addr          = link_r;

    // Mask is cleared by the bench for nesting and set before exit
    always_ff @(negedge clk or posedge reset)
    begin
        if (reset)
        begin
            vector_read_reg <= 1'b0;
            handler_addr    <= 32'h0;
            link_r          <= 32'h0;
            pc_r            <= 32'h0;
            adjust_r        <= 1'b0;
        end
        else
        begin
            adjust_r <= 1'b0;
            if (!core_request_n && !irq_mask && !vector_read_reg)
            begin
                link_r          <= pc_r;
                pc_r            <= 32'h0000_0018;
                adjust_r        <= 1'b1;
                vector_read_reg <= 1'b1;
            end
            else
                vector_read_reg <= 1'b0;
            if (adjust_r)
                link_r <= link_r - 32'h4;
            // Branch to the handler so a nested entry saves its address
            if (vector_read_reg)
            begin
                handler_addr <= vector_data;
                pc_r         <= vector_data;
            end
        end
    end
endmodule
`default_nettype wire

// *** sim/irq_vectoring_nesting_bench.sv ***
// Purpose: Self-checking bench for the vectored interrupt path
// Assumes: Core model acknowledges whenever unmasked
// Notes:   Handler address of source i is 1000_0000 plus i
`timescale 1ns/1ps
`default_nettype none
module irq_vectoring_nesting_bench;
    logic        clk           = 1'b0;
    logic        reset         = 1'b1;
    logic [31:0] src_in        = 32'h0;
    logic [31:0] src_enable    = 32'h7fff_ffff;
    logic [31:0] src_edge_mode = 32'h0;
    logic [95:0] src_prio      = 96'h0;
    logic        vec_wr        = 1'b0;
    logic [4:0]  vec_wr_idx    = 5'h00;
    logic [31:0] vec_wr_data   = 32'h0;
    logic        irq_mask      = 1'b0;
    logic        eos_go        = 1'b0;
    logic        clk_en        = 1'b1;
    wire         rd;
    wire         eos;
    wire         req_n;
    wire         in_svc;
    wire  [31:0] vdata;
    wire  [31:0] haddr;
    wire  [31:0] link;
    wire  [2:0]  lvl;
    wire  [4:0]  csrc;
    int          fail_count    = 0;
    int          checks_done   = 0;
    int          cycles        = 0;

    irq_vectoring_nesting DUT (.clk(clk), .reset(reset), .clk_en(clk_en), .src_in(src_in),
        .src_enable(src_enable), .src_edge_mode(src_edge_mode), .src_prio(src_prio),
        .vec_wr(vec_wr), .vec_wr_idx(vec_wr_idx), .vec_wr_data(vec_wr_data),
        .vector_read_reg(rd), .end_of_service_reg(eos), .core_request_n(req_n),
        .vector_data(vdata), .current_level(lvl), .current_source(csrc), .in_service(in_svc));
    core_model core (.clk(clk), .reset(reset), .core_request_n(req_n), .vector_data(vdata),
        .irq_mask(irq_mask), .eos_go(eos_go), .vector_read_reg(rd),
        .end_of_service_reg(eos), .handler_addr(haddr), .link_addr(link));

    initial forever #4 clk = ~clk;

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cfg(input int i, input int p, input logic e);
        src_prio[3*i +: 3] = 3'(p);
        src_edge_mode[i]   = e;
    endtask

    task automatic pulse(input int i);
        src_in[i] = 1'b1;
        repeat (3) @(negedge clk);
        src_in[i] = 1'b0;
    endtask

    // Waits for the core to acknowledge, then judges the new current state
    task automatic take(input int s, input int l);
        int n;
        n = 0;
        while (rd !== 1'b1 && n < 40)
        begin
            @(posedge clk);
            n++;
        end
        repeat (2) @(negedge clk);
        check(haddr, 32'h1000_0000 + 32'(s));
        check(32'(csrc), 32'(s));
        check(32'(lvl), 32'(l));
        check(32'(req_n), 32'h1);
    endtask

    task automatic end_service();
        eos_go = 1'b1;
        @(negedge clk);
        eos_go = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic s_edge();
        cfg(3, 2, 1'b1);
        cfg(31, 7, 1'b0);
        src_in[31] = 1'b1;
        repeat (6) @(negedge clk);
        check(32'(req_n), 32'h1);
        pulse(3);
        take(3, 2);
        check(32'(in_svc), 32'h1);
        end_service();
        check(32'(in_svc), 32'h0);
        check(32'(req_n), 32'h1);
        src_in[31] = 1'b0;
    endtask

    task automatic s_nest();
        cfg(5, 6, 1'b0);
        cfg(4, 6, 1'b0);
        cfg(7, 7, 1'b1);
        src_in[5:4] = 2'h3;
        take(4, 6);
        pulse(7);
        take(7, 7);
        check(link, 32'h1000_0000);
        end_service();
        check(32'(lvl), 32'h6);
        check(32'(csrc), 32'h4);
        check(32'(req_n), 32'h1);
        src_in[5:4] = 2'h0;
        repeat (4) @(negedge clk);
        end_service();
        check(32'(in_svc), 32'h0);
        end_service();
        check(32'(lvl), 32'h0);
        check(32'(in_svc), 32'h0);
    endtask

    task automatic s_reraise();
        cfg(9, 1, 1'b0);
        cfg(10, 5, 1'b1);
        cfg(11, 3, 1'b1);
        src_in[9] = 1'b1;
        take(9, 1);
        pulse(10);
        take(10, 5);
        pulse(11);
        repeat (4) @(negedge clk);
        check(32'(req_n), 32'h1);
        irq_mask = 1'b1;
        end_service();
        check(32'(lvl), 32'h1);
        check(32'(req_n), 32'h0);
        irq_mask = 1'b0;
        take(11, 3);
        src_in[9] = 1'b0;
        end_service();
        repeat (4) @(negedge clk);
        end_service();
        check(32'(in_svc), 32'h0);
    endtask

    // Frozen block must not see a new source until the enable returns
    task automatic s_freeze();
        cfg(8, 2, 1'b0);
        clk_en    = 1'b0;
        src_in[8] = 1'b1;
        repeat (6) @(negedge clk);
        check(32'(req_n), 32'h1);
        check(32'(in_svc), 32'h0);
        clk_en = 1'b1;
        take(8, 2);
        src_in[8] = 1'b0;
        repeat (4) @(negedge clk);
        end_service();
        check(32'(in_svc), 32'h0);
    endtask

    task automatic s_depth();
        for (int k = 0; k < 8; k++)
        begin
            cfg(12 + k, k, 1'b1);
            pulse(12 + k);
            take(12 + k, k);
        end
        for (int k = 7; k >= 0; k--)
        begin
            check(32'(lvl), 32'(k));
            end_service();
        end
        check(32'(in_svc), 32'h0);
    endtask

    initial
    begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        for (int i = 1; i < 32; i++)
        begin
            @(negedge clk);
            vec_wr      = 1'b1;
            vec_wr_idx  = 5'(i);
            vec_wr_data = 32'h1000_0000 + 32'(i);
        end
        @(negedge clk);
        vec_wr = 1'b0;
        s_edge();
        s_nest();
        s_reraise();
        s_depth();
        s_freeze();
        finish_test();
    end
endmodule
`default_nettype wire
